// ---- hw/fba_pkg.sv ----
// package: constants, types and state record of the focus balance auto adjust block
package fba_pkg;

    // register byte offsets on the avalon slave
    localparam logic [3:0]  FBA_OFS_CTRL      = 4'h0;
    localparam logic [3:0]  FBA_OFS_DWELL     = 4'h4;
    localparam logic [3:0]  FBA_OFS_STATUS    = 4'h8;
    localparam logic [3:0]  FBA_OFS_ERRCNT    = 4'hc;

    // control fields
    localparam int          FBA_CTRL_PLAY_BIT    = 0;
    localparam int          FBA_CTRL_RESTART_BIT = 1;

    // status fields
    localparam int          FBA_STAT_BUSY_BIT    = 0;
    localparam int          FBA_STAT_DONE_BIT    = 1;
    localparam int          FBA_STAT_STEP_LSB    = 4;
    localparam int          FBA_STAT_BEST_LSB    = 8;
    localparam int          FBA_STAT_SEL_LSB     = 12;

    // reset values and limits
    localparam logic [7:0]  FBA_DWELL_RST     = 8'h10;
    localparam logic [7:0]  FBA_CNT_MAX       = 8'hff;
    localparam logic [3:0]  FBA_STEP_FIRST    = 4'h0;
    localparam logic [3:0]  FBA_STEP_LAST     = 4'h8;
    localparam logic [3:0]  FBA_STEP_INH      = 4'h0;
    localparam int          FBA_SR_W          = 8;

    typedef enum logic [1:0] {
        FBA_IDLE,
        FBA_MEASURE
    } fba_state_t;

    // avalon-mm request from the master
    typedef struct packed {
        logic        read;
        logic        write;
        logic [3:0]  address;
        logic [31:0] writedata;
    } fba_avs_req_t;

    // avalon-mm answer to the master
    typedef struct packed {
        logic        waitrequest;
        logic [31:0] readdata;
    } fba_avs_rsp_t;

    // select code toward the 8-channel resistor multiplexer
    typedef struct packed {
        logic        mux_inhibit;
        logic [2:0]  level;
    } fba_sel_t;

    // whole state of the block
    typedef struct packed {
        logic                 wck_meta;
        logic                 wck_sync;
        logic                 wck_prev;
        logic                 frm_meta;
        logic                 frm_sync;
        logic                 frm_prev;
        logic                 err_meta;
        logic                 err_sync;
        logic [FBA_SR_W-1:0]  shreg;
        logic [FBA_SR_W-1:0]  latched;
        logic                 frame_pend;
        logic                 ack;
        logic [31:0]          rdata;
        logic                 play;
        logic                 play_prev;
        logic [7:0]           dwell;
        fba_state_t           state;
        logic                 done;
        logic [3:0]           step;
        logic [3:0]           best_step;
        logic [7:0]           frame_cnt;
        logic [7:0]           err_cnt;
        logic [7:0]           best_cnt;
        fba_sel_t             sel;
    } fba_st_t;

endpackage : fba_pkg

// ---- hw/fba_servo_balance_control.sv ----
// focus balance auto adjust: error frame counter and resistor step selector
//
// Contract
// - new adjustment starts on disc exchange or on stop-to-play change
// - pick one of nine balance steps by decoding error count
// - error flag shifts in on word clock, latched out on frame pulse
// - latched shift outputs ORed into one per-frame error indication
// - count error frames, drive inhibit plus three address lines to mux
// - inhibit high disconnects all; else C,B,A binary level 0 to 7
// - settle on the step with about the lowest error count tried
`timescale 1ns/1ps
module fba_servo_balance_control
    import fba_pkg::*;
(
    // clock and reset
    input  wire logic          sys_clk_in,
    input  wire logic          arst_n_in,
    // register bus
    input  wire fba_avs_req_t  avs_req_in,
    output fba_avs_rsp_t       avs_rsp_out,
    // decoder pins, asynchronous to sys_clk_in
    input  wire logic          decode_error_flag_in,
    input  wire logic          word_period_clock_in,
    input  wire logic          frame_latch_pulse_in,
    // resistor multiplexer select
    output fba_sel_t           mux_sel_out
);

    // whole block state lives in one record; the comb block below builds
    // its successor and a single flop process registers it, so no field
    // can be forgotten in reset or left without a next value
    // the record is wide, but every bit of it is plain flops
    fba_st_t st_reg;
    fba_st_t st_next;

    // combinational helpers; decoded once here so the sequencer and the
    // bus decode read the same strobes within a cycle
    logic       wck_rise;
    logic       frm_rise;
    logic       acc;
    logic       wr_go;
    logic       trig;
    logic       frame_err;
    logic [7:0] dwell_eff;
    logic [7:0] fc_new;
    logic [7:0] ec_new;

    // next-state logic for the whole block
    // every field defaults to its held value, so a field left untouched
    // on some path keeps its state instead of inferring a latch
    always_comb begin
        st_next   = st_reg;
        wck_rise  = st_reg.wck_sync & ~st_reg.wck_prev;
        frm_rise  = st_reg.frm_sync & ~st_reg.frm_prev;
        acc       = avs_req_in.read | avs_req_in.write;
        wr_go     = avs_req_in.write & st_reg.ack;
        trig      = 1'b0;
        frame_err = |st_reg.latched;
        dwell_eff = (st_reg.dwell == 8'h00) ? 8'h01 : st_reg.dwell;
        fc_new    = st_reg.frame_cnt + 8'h01;
        ec_new    = st_reg.err_cnt;

        // two-stage synchronisers; the first stage is never read by logic
        // the decoder pins run on their own oscillator, so each one passes
        // two flops before any logic; a third flop gives the edge detect,
        // which means every pin phase must last longer than one clock to be seen
        // the error flag needs no edge detect, it is sampled as a level
        st_next.wck_meta = word_period_clock_in;
        st_next.wck_sync = st_reg.wck_meta;
        st_next.wck_prev = st_reg.wck_sync;
        st_next.frm_meta = frame_latch_pulse_in;
        st_next.frm_sync = st_reg.frm_meta;
        st_next.frm_prev = st_reg.frm_sync;
        st_next.err_meta = decode_error_flag_in;
        st_next.err_sync = st_reg.err_meta;

        // strobed shift register: shift on word clock, latch on frame pulse
        // the latch copy is what the counter sees, so the shift chain can
        // keep filling with the next frame's flags while this one is judged
        // the chain holds only the last eight words of each frame
        if (wck_rise) begin
            st_next.shreg = {st_reg.shreg[FBA_SR_W-2:0], st_reg.err_sync};
        end
        if (frm_rise) begin
            st_next.latched = st_reg.shreg;
        end
        // OR is taken one cycle later, from the latched copy
        // the one-cycle lag lets the latch settle before the OR is read;
        // any single erring word marks the whole frame
        st_next.frame_pend = frm_rise;

        // avalon slave: one wait cycle, answer on the second cycle
        // read data is captured while waitrequest is still high, so it is
        // already standing from a flop at the edge where the master takes it;
        // the price is one fixed wait state on every access
        // ack clears itself after one cycle, so back-to-back requests work
        st_next.ack = acc & ~st_reg.ack;
        if (acc & ~st_reg.ack & avs_req_in.read) begin
            unique case (avs_req_in.address)
                FBA_OFS_CTRL:   st_next.rdata = {31'h0, st_reg.play};
                FBA_OFS_DWELL:  st_next.rdata = {24'h0, st_reg.dwell};
                FBA_OFS_STATUS: begin
                    st_next.rdata = 32'h0;
                    st_next.rdata[FBA_STAT_BUSY_BIT] = (st_reg.state == FBA_MEASURE);
                    st_next.rdata[FBA_STAT_DONE_BIT] = st_reg.done;
                    st_next.rdata[FBA_STAT_STEP_LSB +: 4] = st_reg.step;
                    st_next.rdata[FBA_STAT_BEST_LSB +: 4] = st_reg.best_step;
                    st_next.rdata[FBA_STAT_SEL_LSB +: 4]  = st_reg.sel;
                end
                FBA_OFS_ERRCNT: st_next.rdata = {16'h0, st_reg.err_cnt, st_reg.best_cnt};
                default:        st_next.rdata = 32'h0;    // unmapped reads as zero
            endcase
        end
        // writes act only at the edge where waitrequest is low, so a held
        // request never writes twice
        if (wr_go) begin
            unique case (avs_req_in.address)
                FBA_OFS_CTRL: begin
                    st_next.play = avs_req_in.writedata[FBA_CTRL_PLAY_BIT];
                    // restart bit stands for a disc exchange, it is not stored
                    trig = avs_req_in.writedata[FBA_CTRL_RESTART_BIT];
                end
                FBA_OFS_DWELL: st_next.dwell = avs_req_in.writedata[7:0];
                default: ;                                    // writes elsewhere ignored
            endcase
        end

        // stop-to-play edge also starts a run
        // play_prev lags play by one clock, so only a low-to-high change of
        // the stored bit fires; rewriting play as one does nothing
        st_next.play_prev = st_reg.play;
        if (st_reg.play & ~st_reg.play_prev) begin
            trig = 1'b1;
        end

        // adjustment sequencer
        // each step is held for the programmed number of frames, one if zero; the count
        // of erring frames is compared against the best seen so far and the
        // winner is restored once the last step has been tried
        // limitation: the first frame after a step change is counted too
        // frames that arrive while idle change nothing
        unique case (st_reg.state)
            FBA_IDLE: ;                                  // select held as chosen
            FBA_MEASURE: begin
                if (st_reg.frame_pend) begin
                    // saturate rather than wrap so a bad step never looks good
                    if (frame_err && st_reg.err_cnt != FBA_CNT_MAX) begin
                        ec_new = st_reg.err_cnt + 8'h01;
                    end
                    st_next.frame_cnt = fc_new;
                    st_next.err_cnt   = ec_new;
                    if (fc_new >= dwell_eff) begin
                        // strict compare keeps the earlier step on a tie
                        if (ec_new < st_reg.best_cnt) begin
                            st_next.best_cnt  = ec_new;
                            st_next.best_step = st_reg.step;
                        end
                        st_next.frame_cnt = 8'h00;
                        st_next.err_cnt   = 8'h00;
                        if (st_reg.step == FBA_STEP_LAST) begin
                            if (ec_new < st_reg.best_cnt) begin
                                st_next.step = st_reg.step;
                            end else begin
                                st_next.step = st_reg.best_step;
                            end
                            st_next.state = FBA_IDLE;
                            st_next.done  = 1'b1;
                        end else begin
                            st_next.step = st_reg.step + 4'h1;
                        end
                    end
                end
            end
            default: st_next.state = FBA_IDLE;
        endcase

        // a trigger restarts from the first step, even mid-run
        // placed after the sequencer so it overrides any step change made in
        // the same cycle; a restart never leaves a half-finished search behind
        if (trig) begin
            st_next.state     = FBA_MEASURE;
            st_next.done      = 1'b0;
            st_next.step      = FBA_STEP_FIRST;
            st_next.best_step = FBA_STEP_FIRST;
            st_next.best_cnt  = FBA_CNT_MAX;
            st_next.frame_cnt = 8'h00;
            st_next.err_cnt   = 8'h00;
        end

        // step 0 is the inhibit setting, steps 1..8 map to levels 0..7
        // decoded from the next step so the select pins move in the same
        // clock as the step register, with no extra cycle of stale code
        if (st_next.step == FBA_STEP_INH) begin
            st_next.sel.mux_inhibit = 1'b1;
            st_next.sel.level       = 3'h0;
        end else begin
            st_next.sel.mux_inhibit = 1'b0;
            st_next.sel.level       = 3'(st_next.step - 4'h1);
        end
    end

    // state register
    // reset puts the multiplexer on inhibit so no balance resistor is
    // switched in before software or a trigger asks for a search
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            st_reg                 <= '0;
            st_reg.dwell           <= FBA_DWELL_RST;
            st_reg.best_cnt        <= FBA_CNT_MAX;
            st_reg.sel.mux_inhibit <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    // outputs; waitrequest is combinational, data from flops
    // the answer record is driven whole by one assignment, so the output
    // has a single driver
    assign avs_rsp_out = '{waitrequest: acc & ~st_reg.ack, readdata: st_reg.rdata};
    assign mux_sel_out             = st_reg.sel;

endmodule : fba_servo_balance_control

// ---- dv/fba_properties.sv ----
// checker: port timing relations of the balance control block
`timescale 1ns/1ps
module fba_properties
    import fba_pkg::*;
(
    // clock, reset
    input wire logic         sys_clk_in,
    input wire logic         arst_n_in,
    // bus, pins, select
    input wire fba_avs_req_t avs_req_in,
    input wire fba_avs_rsp_t avs_rsp_out,
    input wire logic         frame_latch_pulse_in,
    input wire fba_sel_t     mux_sel_out
);
    logic       acc_ctrl;
    logic       frm_prev_reg;
    logic       play_reg;
    logic [7:0] frm_age_reg;
    logic [7:0] wr_age_reg;
    assign acc_ctrl = avs_req_in.write & ~avs_rsp_out.waitrequest
                    & (avs_req_in.address == FBA_OFS_CTRL);
    // ages since last frame edge and ctrl write, saturating
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            frm_prev_reg <= 1'b0;
            play_reg     <= 1'b0;
            frm_age_reg  <= 8'hff;
            wr_age_reg   <= 8'hff;
        end else begin
            frm_prev_reg <= frame_latch_pulse_in;
            frm_age_reg  <= (frame_latch_pulse_in && !frm_prev_reg) ? 8'h00
                          : frm_age_reg + {7'h0, frm_age_reg != 8'hff};
            wr_age_reg   <= acc_ctrl ? 8'h00 : wr_age_reg + {7'h0, wr_age_reg != 8'hff};
            if (acc_ctrl) play_reg <= avs_req_in.writedata[0];
        end
    end
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!arst_n_in);
    sequence s_trig;
        acc_ctrl && (avs_req_in.writedata[1] || (avs_req_in.writedata[0] && !play_reg));
    endsequence
    sequence s_inh_hold;
        (mux_sel_out == 4'h8) [*8];
    endsequence
    a_inh_level_zero:
        assert property (mux_sel_out.mux_inhibit |-> mux_sel_out.level == 3'h0)
        else $error("level set under inhibit");
    a_restart_inhibit:
        assert property (acc_ctrl && avs_req_in.writedata[1] |-> ##[1:3] mux_sel_out == 4'h8)
        else $error("restart did not select inhibit");
    a_play_start:
        assert property (acc_ctrl && avs_req_in.writedata[0] && !play_reg
                         |-> ##[1:4] mux_sel_out == 4'h8)
        else $error("play edge did not start a run");
    a_first_step_dwell:
        assert property (s_trig |-> ##[1:4] s_inh_hold)
        else $error("first step left too soon");
    a_sel_after_frame:
        assert property ($changed(mux_sel_out) |-> frm_age_reg < 8'h10 || wr_age_reg < 8'h08)
        else $error("select moved without frame or trigger");
    a_one_wait_cycle:
        assert property ($rose(avs_req_in.read | avs_req_in.write)
                         |-> avs_rsp_out.waitrequest ##1 !avs_rsp_out.waitrequest)
        else $error("bus wait not one cycle");
    a_unmapped_zero:
        assert property (avs_req_in.read && !avs_rsp_out.waitrequest
                         && avs_req_in.address == 4'h2 |-> avs_rsp_out.readdata == 32'h0)
        else $error("unmapped read not zero");
    a_done_shows_sel:
        assert property (avs_req_in.read && !avs_rsp_out.waitrequest
                         && avs_req_in.address == FBA_OFS_STATUS && avs_rsp_out.readdata[1]
                         |-> avs_rsp_out.readdata[15:12] == $past(mux_sel_out))
        else $error("status select differs from pins");
endmodule : fba_properties
bind fba_servo_balance_control fba_properties fba_properties_i (
    .sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in), .avs_req_in(avs_req_in),
    .avs_rsp_out(avs_rsp_out), .frame_latch_pulse_in(frame_latch_pulse_in),
    .mux_sel_out(mux_sel_out));

// ---- dv/fba_disc_model.sv ----
// model: decoder pins plus resistor network, error rate set per balance step
`timescale 1ns/1ps
module fba_disc_model
    import fba_pkg::*;
(
    input  wire logic       clk_in,
    input  wire logic       rst_n_in,
    input  wire fba_sel_t   sel_in,
    input  wire logic [8:0] bad_in,
    output logic            err_out,
    output logic            word_out,
    output logic            frame_out
);
    logic [7:0] cnt_reg;
    // scaled word period of 32 clocks, 8 words a frame; flag follows the step
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_reg <= 8'h00;
            err_out <= 1'b0;
        end else begin
            cnt_reg <= cnt_reg + 8'h01;
            err_out <= bad_in[sel_in.mux_inhibit ? 4'h0 : {1'b0, sel_in.level} + 4'h1];
        end
    end
    assign word_out  = cnt_reg[4];
    assign frame_out = cnt_reg[7:2] == 6'h00; // mid-gap between word rising edges, on a word falling edge
endmodule : fba_disc_model

// ---- dv/tb.sv ----
// testbench: bus scenarios and select sequence checks
`timescale 1ns/1ps
module tb
    import fba_pkg::*;
;
    logic sys_clk_in = 1'b0, arst_n_in = 1'b0, err, wck, frm;
    fba_avs_req_t req = '0;
    fba_avs_rsp_t rsp;
    fba_sel_t sel, sel_last = 4'h8, pushed = 4'h8, sq[$];
    logic [8:0] bad = 9'h001;
    logic [63:0] rq[$];
    logic [31:0] rd_last, x = 32'd32;
    int fail_count = 0, n_tests = 0;
    fba_servo_balance_control fba_servo_balance_control_i (.sys_clk_in(sys_clk_in),
        .arst_n_in(arst_n_in), .avs_req_in(req), .avs_rsp_out(rsp),
        .decode_error_flag_in(err), .word_period_clock_in(wck),
        .frame_latch_pulse_in(frm), .mux_sel_out(sel));
    fba_disc_model fba_disc_model_i (.clk_in(sys_clk_in), .rst_n_in(arst_n_in), .sel_in(sel),
        .bad_in(bad), .err_out(err), .word_out(wck), .frame_out(frm));
    initial forever #5 sys_clk_in = ~sys_clk_in;
    function automatic logic [31:0] xs();
        x ^= x << 13; x ^= x >> 17; x ^= x << 5;
        return x;
    endfunction : xs
    task automatic cmp_rd(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin fail_count++; $display("[ERR] %0t read %h exp %h", $time, g, e); end
    endtask : cmp_rd
    task automatic cmp_sel(input fba_sel_t g, input fba_sel_t e);
        n_tests++;
        if (g !== e) begin fail_count++; $display("[ERR] %0t sel %h exp %h", $time, g, e); end
    endtask : cmp_sel
    task automatic close_out();
        $display("compares %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : close_out
    // one avalon transfer; e holds {mask, expected}, zero mask skips compare
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                       input logic [63:0] e);
        int t;
        t = 0;
        @(posedge sys_clk_in);
        req <= '{read: !w, write: w, address: a, writedata: d};
        if (!w) rq.push_back(e);
        do begin @(posedge sys_clk_in); t++; end while (rsp.waitrequest !== 1'b0 && t < 50);
        req <= '0;
        if (t >= 50) begin fail_count++; $display("[ERR] %0t bus timeout", $time); end
    endtask : bus
    task automatic push_sel(input int k);
        fba_sel_t c;
        c = (k == 0) ? 4'h8 : 4'(k - 1);
        if (c !== pushed) sq.push_back(c);
        pushed = c;
    endtask : push_sel
    // read data taken at the edge where waitrequest is low
    always @(posedge sys_clk_in) if (req.read && rsp.waitrequest === 1'b0) begin
        rd_last = rsp.readdata;
        if (rq[0][63:32] != 0) cmp_rd(rsp.readdata & rq[0][63:32], rq[0][31:0]);
        void'(rq.pop_front());
    end
    // every select change must be the next noted code
    always @(posedge sys_clk_in) if (arst_n_in && sel !== sel_last) begin
        sel_last = sel;
        cmp_sel(sel, sq.size() ? sq.pop_front() : ~sel);
    end
    initial begin
        int b;
        logic [31:0] v;
        repeat (8) @(posedge sys_clk_in);
        arst_n_in <= 1'b1;
        bus(1'b1, FBA_OFS_DWELL, 32'h2, '0);
        bus(1'b0, FBA_OFS_DWELL, 0, {32'hff, 32'h2});
        bus(1'b0, 4'h2, 0, {32'hffffffff, 32'h0});
        for (int r = 0; r < 4; r++) begin
            v = (r == 3) ? '1 : xs();
            bad <= v[8:0] | 9'h001; // inhibit step always erring keeps counts exact
            repeat (300) @(posedge sys_clk_in); // let the shift chain refill under the new pattern
            b = 0;
            for (int k = 8; k > 0; k--) if (!v[k]) b = k;
            for (int k = 0; k < 9; k++) push_sel(k);
            push_sel(b);
            if (r[0]) bus(1'b1, FBA_OFS_CTRL, 32'h2, '0);
            else begin bus(1'b1, FBA_OFS_CTRL, 0, '0); bus(1'b1, FBA_OFS_CTRL, 32'h1, '0); end
            repeat (4) @(posedge sys_clk_in);
            v = 0;
            for (int t = 0; t < 100 && !v[1]; t++) begin
                repeat (100) @(posedge sys_clk_in);
                bus(1'b0, FBA_OFS_STATUS, 0, '0);
                @(negedge sys_clk_in);
                v = rd_last;
            end
            bus(1'b0, FBA_OFS_STATUS, 0, {32'hff03, 16'h0, pushed, 4'(b), 8'h02});
            bus(1'b0, FBA_OFS_ERRCNT, 0, {32'hff, (b != 0) ? 32'h0 : 32'h2});
        end
        bus(1'b0, FBA_OFS_CTRL, 0, {32'h3, 32'h0});
        repeat (1200) @(posedge sys_clk_in);
        cmp_sel(sel, pushed);
        cmp_rd(32'(sq.size()), 32'h0);
        close_out();
    end
    initial begin
        #600us;
        fail_count++;
        close_out();
    end
endmodule : tb
